// ===== design/io_port_pkg.sv
// Shared constants and carriers for the isolated digital I/O port
package io_port_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int PADDR_W     = 18;
   localparam int PDATA_W     = 32;
   localparam int GROUP_W     = 8;
   localparam int PORT_W      = 16;
   localparam int IO_ADDR_W   = 16;
   localparam int IO_ADDR_LSB = 2;

   // ************************************************************
   // Locations, byte offsets from the switch base (base times four)
   // ************************************************************
   localparam logic [PADDR_W-1:0] LOC_LOW_OFFSET  = 18'h00000;
   localparam logic [PADDR_W-1:0] LOC_HIGH_OFFSET = 18'h00004;
   localparam int                 LOC_SEL_BIT     = 0;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int LOW_GROUP_LSB  = 0;
   localparam int HIGH_GROUP_LSB = 8;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [PORT_W-1:0]  OUTPUT_RESET    = 16'h0000;
   localparam logic [PORT_W-1:0]  INPUT_PIN_RESET = 16'hFFFF;
   localparam logic [PDATA_W-1:0] PRDATA_RESET    = 32'h00000000;
   localparam logic [3:0]         CFG_RESET       = 4'h2;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed
   {
      logic word_mode;
      logic addr16;
      logic protect;
      logic reset_link;
   } bus_cfg_t;

   typedef struct packed
   {
      logic [GROUP_W-1:0] high;
      logic [GROUP_W-1:0] low;
   } port16_t;

endpackage

// ===== design/pin_sync.sv
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module pin_sync
#(
   parameter int                 WIDTH       = 1,
   parameter logic [WIDTH-1:0]   RESET_VALUE = '0
)
(
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // ************************************************************
   // Stage one is read by stage two only
   // ************************************************************
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         stage1   <= RESET_VALUE;
         sync_out <= RESET_VALUE;
      end
      else
      begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

// ===== design/isolated_digital_io_port.sv
// APB-attached isolated 16-in / 16-out digital port with output protection
//
// Behaviour
// R1 - Two locations; reads give inputs, writes outputs
// R2 - Usable at once after reset, no setup
// R3 - Reset holds all sixteen outputs inactive
// R4 - Jumper can exclude the output protection
// R5 - Protection released only after a register write
// R6 - First write lights that register's own LED
// R7 - Each output has an indicator while active
// R8 - Each input drives an indicator of status
// R9 - Byte or word data mode, jumper, shown
// R10 - Decode 8-bit or 16-bit I/O addresses
// R11 - Two switch banks set compared base address
// R12 - Three LEDs show the bus configuration
// R13 - Option links bus reset or isolates it
// R14 - Chip selects derived from decoded access
// R15 - Output latches hold until next written
// R16 - Input buffers enabled only during reads
// R17 - Input pulled to common reads active
// R18 - Byte write one group, word both
// R19 - Host writes each group before expecting outputs
`timescale 1ns/1ps
module isolated_digital_io_port
   import io_port_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               resetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [PADDR_W-1:0] paddr,
   input  wire logic [PDATA_W-1:0] pwdata,
   output logic      [PDATA_W-1:0] prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic [GROUP_W-1:0] input_group_low_n,
   input  wire logic [GROUP_W-1:0] input_group_high_n,
   input  wire logic [GROUP_W-1:0] base_address_switch_a,
   input  wire logic [GROUP_W-1:0] base_address_switch_b,
   input  wire logic               word_mode_jumper,
   input  wire logic               addr16_jumper,
   input  wire logic               protect_jumper,
   input  wire logic               reset_link_jumper,
   input  wire logic               bus_reset_n,
   output logic      [GROUP_W-1:0] output_group_low,
   output logic      [GROUP_W-1:0] output_group_high,
   output logic      [PORT_W-1:0]  output_led,
   output logic      [PORT_W-1:0]  input_led,
   output logic                    reg_led_low,
   output logic                    reg_led_high,
   output logic                    data16_led,
   output logic                    addr16_led,
   output logic                    reset_link_led
);

   // ************************************************************
   // Decode helpers
   // ************************************************************
   function automatic logic board_hit
   (
      input logic [IO_ADDR_W-1:0] addr,
      input logic                 wide,
      input logic [IO_ADDR_W-1:0] base
   );
      // Bit 0 picks the location, so only the upper bits meet the base
      if (wide)
         board_hit = (addr[IO_ADDR_W-1:1] == base[IO_ADDR_W-1:1]); // R10 R11
      else
         board_hit = (addr[GROUP_W-1:1] == base[GROUP_W-1:1]);     // R10 R11
   endfunction

   function automatic logic [1:0] group_select
   (
      input logic loc_high,
      input logic word
   );
      // Word mode always takes both groups together
      if (word)
         group_select = 2'h3;                      // R18
      else
         group_select = loc_high ? 2'h2 : 2'h1;    // R18
   endfunction

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [PORT_W-1:0]  in_pins_sync;
   logic [PORT_W-1:0]  switch_sync;
   logic [4:0]         jumper_sync;

   pin_sync #(.WIDTH(PORT_W), .RESET_VALUE(INPUT_PIN_RESET)) u_in_sync
   (
      .clk      (clk),
      .resetn   (resetn),
      .async_in ({input_group_high_n, input_group_low_n}),
      .sync_out (in_pins_sync)
   );

   pin_sync #(.WIDTH(PORT_W), .RESET_VALUE(OUTPUT_RESET)) u_sw_sync
   (
      .clk      (clk),
      .resetn   (resetn),
      .async_in ({base_address_switch_b, base_address_switch_a}),
      .sync_out (switch_sync)
   );

   // Reset value matches the cfg reset so no mode flickers after release
   pin_sync #(.WIDTH(5), .RESET_VALUE({1'b1, CFG_RESET})) u_jmp_sync
   (
      .clk      (clk),
      .resetn   (resetn),
      .async_in ({bus_reset_n, word_mode_jumper, addr16_jumper,
                  protect_jumper, reset_link_jumper}),
      .sync_out (jumper_sync)
   );

   // ************************************************************
   // Configuration and state
   // ************************************************************
   bus_cfg_t           cfg;
   port16_t            in_state;
   port16_t            latch;
   logic               arm_low;
   logic               arm_high;
   logic               bus_reset_hit;
   logic [IO_ADDR_W-1:0] io_addr;
   logic               hit;
   logic               loc_high;
   logic               answer;
   logic               take;
   logic               in_buf_sel;
   logic [1:0]         out_latch_sel;
   logic [PDATA_W-1:0] next_prdata;
   logic [PORT_W-1:0]  next_drive;

   // Active field contact pulls the pin to common, i.e. low
   assign in_state      = ~in_pins_sync;                              // R17
   assign bus_reset_hit = cfg.reset_link & ~jumper_sync[4];           // R13

   // Jumpers are levels; one register stage keeps the LEDs flop-driven
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         cfg <= CFG_RESET;
      else
         cfg <= bus_cfg_t'(jumper_sync[3:0]);
   end

   // ************************************************************
   // APB decode and chip selects
   // ************************************************************
   assign io_addr  = paddr[IO_ADDR_LSB +: IO_ADDR_W];
   assign hit      = board_hit(io_addr, cfg.addr16, switch_sync);
   assign loc_high = io_addr[LOC_SEL_BIT];                             // R1
   // Answer in the second access cycle; no setup sequence needed
   assign answer   = psel & penable & ~pready;                         // R2
   assign take     = psel & penable & pready & pwrite & hit;
   assign in_buf_sel    = answer & hit & ~pwrite;                      // R14 R16
   assign out_latch_sel = take ? group_select(loc_high, cfg.word_mode) : 2'h0; // R14

   always_comb
   begin
      next_prdata = PRDATA_RESET;
      if (in_buf_sel)                                                  // R16
      begin
         if (cfg.word_mode)                                            // R9
            next_prdata[PORT_W-1:0] = in_state;
         else if (loc_high)
            next_prdata[GROUP_W-1:0] = in_state.high;                  // R1
         else
            next_prdata[GROUP_W-1:0] = in_state.low;                   // R1
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= PRDATA_RESET;
      end
      else
      begin
         pready  <= answer;
         // Another board may own the address; APB still needs an answer
         pslverr <= answer & ~hit;
         prdata  <= next_prdata;
      end
   end

   // ************************************************************
   // Output latches and protection
   // ************************************************************
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         latch <= OUTPUT_RESET;
      else
      begin
         if (out_latch_sel[0])                                         // R15 R18
            latch.low <= cfg.word_mode ? pwdata[LOW_GROUP_LSB +: GROUP_W]
                                       : pwdata[GROUP_W-1:0];
         if (out_latch_sel[1])                                         // R15 R18
            latch.high <= cfg.word_mode ? pwdata[HIGH_GROUP_LSB +: GROUP_W]
                                        : pwdata[GROUP_W-1:0];
      end
   end

   // Bus reset drops arming only; latches survive so an unprotected
   // board keeps driving its loads through a backplane reset
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         arm_low  <= 1'b0;                                             // R3
         arm_high <= 1'b0;                                             // R3
      end
      else if (bus_reset_hit)
      begin
         arm_low  <= 1'b0;                                             // R13
         arm_high <= 1'b0;                                             // R13
      end
      else
      begin
         if (out_latch_sel[0])
            arm_low <= 1'b1;                                           // R5 R19
         if (out_latch_sel[1])
            arm_high <= 1'b1;                                          // R5 R19
      end
   end

   always_comb
   begin
      next_drive = latch;
      if (cfg.protect)                                                 // R4
         next_drive = latch & {{GROUP_W{arm_high}}, {GROUP_W{arm_low}}}; // R3 R5
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         output_group_low  <= OUTPUT_RESET[GROUP_W-1:0];
         output_group_high <= OUTPUT_RESET[GROUP_W-1:0];
         output_led        <= OUTPUT_RESET;
      end
      else
      begin
         output_group_low  <= next_drive[GROUP_W-1:0];
         output_group_high <= next_drive[PORT_W-1:GROUP_W];
         output_led        <= next_drive;                              // R7
      end
   end

   // ************************************************************
   // Indicators
   // ************************************************************
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         input_led      <= OUTPUT_RESET;
         reg_led_low    <= 1'b0;
         reg_led_high   <= 1'b0;
         data16_led     <= 1'b0;
         addr16_led     <= 1'b0;
         reset_link_led <= 1'b0;
      end
      else
      begin
         input_led      <= in_state;                                   // R8 R17
         reg_led_low    <= arm_low;                                    // R6
         reg_led_high   <= arm_high;                                   // R6
         data16_led     <= cfg.word_mode;                              // R9 R12
         addr16_led     <= cfg.addr16;                                 // R12
         reset_link_led <= cfg.reset_link;                             // R12
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_answer_delay: assert property (                                   // R2
      psel && penable && !pready |=> pready)
      else $error("no answer one cycle into access");

   a_unmapped_error: assert property (                                 // R11
      answer && !hit |=> pready && pslverr && prdata == 32'h00000000)
      else $error("unmapped access not flagged");

   a_write_no_data: assert property (                                  // R1
      answer && pwrite |=> prdata == 32'h00000000)
      else $error("read data driven on a write");

   a_read_byte_low: assert property (                                  // R16
      answer && hit && !pwrite && !cfg.word_mode && !loc_high
      |=> prdata == {24'h000000, $past(in_state.low)})
      else $error("byte read of low group wrong");

   a_read_word: assert property (                                      // R9
      answer && hit && !pwrite && cfg.word_mode
      |=> prdata == {16'h0000, $past(in_state)})
      else $error("word read wrong");

   a_protect_hold: assert property (                                   // R3
      $past(cfg.protect && !arm_low) |-> output_group_low == 8'h00)
      else $error("low outputs active before arming");

   a_protect_off: assert property (                                    // R4
      $past(!cfg.protect) |-> {output_group_high, output_group_low} == $past(latch))
      else $error("outputs gated while protection excluded");

   a_arm_led: assert property (                                        // R6
      take && !cfg.word_mode && loc_high && !bus_reset_hit
      |=> arm_high ##1 reg_led_high)
      else $error("write did not light the register LED");

   a_latch_hold: assert property (                                     // R15
      !take |=> $stable(latch))
      else $error("latch changed without a write");

   a_byte_group: assert property (                                     // R18
      take && !cfg.word_mode && !loc_high
      |=> latch.low == $past(pwdata[7:0]) && latch.high == $past(latch.high))
      else $error("byte write touched the wrong group");

   a_word_both: assert property (                                      // R18
      take && cfg.word_mode |=> latch == $past(pwdata[15:0])
      && (arm_low && arm_high || $past(bus_reset_hit)))
      else $error("word write did not load both groups");

   a_bus_reset: assert property (                                      // R13
      bus_reset_hit |=> !arm_low && !arm_high ##1 !reg_led_low && !reg_led_high)
      else $error("linked bus reset did not disarm");

   a_input_led: assert property (                                      // R8
      input_led == ~$past(in_pins_sync))
      else $error("input indicator out of step");

   a_output_led: assert property (                                     // R7
      output_led == {output_group_high, output_group_low})
      else $error("output indicator differs from output");

   c_word_write: cover property (take && cfg.word_mode);
   c_byte_read_high: cover property (in_buf_sel && !cfg.word_mode && loc_high);
   c_arm_then_drive: cover property (take ##2 output_group_low != 8'h00);
   c_bus_reset_armed: cover property (arm_low && bus_reset_hit);

endmodule

// ===== sim/host_model.sv
// Host board model: APB master that issues one transfer at a time
`timescale 1ns/1ps
module host_model
   import io_port_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               pready,
   input  wire logic               pslverr,
   input  wire logic [PDATA_W-1:0] prdata,
   output logic                    psel,
   output logic                    penable,
   output logic                    pwrite,
   output logic      [PADDR_W-1:0] paddr,
   output logic      [PDATA_W-1:0] pwdata
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end

   // ************************************************************
   // Transfer
   // ************************************************************
   // Released lines are inverted so stale values never look valid
   task automatic xfer(input logic wr, input logic [PADDR_W-1:0] a,
      input logic [PDATA_W-1:0] d, output logic [PDATA_W-1:0] rd, output logic er);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= ~wr;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

// ===== sim/test_isolated_digital_io_port.sv
// Self-checking bench for the isolated digital I/O port
`timescale 1ns/1ps
module test_isolated_digital_io_port
   import io_port_pkg::*;
;
   typedef struct packed
   {
      logic               wr;
      logic [PADDR_W-1:0] addr;
      logic [PDATA_W-1:0] data;
      logic               err;
      logic [PDATA_W-1:0] rd;
      logic [PORT_W-1:0]  outx;
      logic [1:0]         leds;
   } row_t;

   logic               clk, resetn, psel, penable, pwrite, pready, pslverr;
   logic [PADDR_W-1:0] paddr;
   logic [PDATA_W-1:0] pwdata, prdata, rd;
   logic [GROUP_W-1:0] in_low_n, in_high_n, sw_a, sw_b, out_low, out_high;
   logic [PORT_W-1:0]  output_led, input_led;
   logic               word_j, addr16_j, protect_j, link_j, bus_reset_n, er;
   logic               reg_led_low, reg_led_high, data16_led, addr16_led, reset_link_led;
   int                 num_errors, checks_done, cycles;

   // Byte mode, 8-bit addressing, base 0x10: low at 0x40, high at 0x44
   row_t rows [8] = '{
      '{1'b0, 18'h00040, 32'h00000000, 1'b0, 32'h000000A5, 16'h0000, 2'h0},
      '{1'b0, 18'h00044, 32'h00000000, 1'b0, 32'h000000F0, 16'h0000, 2'h0},
      '{1'b1, 18'h00040, 32'hFFFFFF33, 1'b0, 32'h00000000, 16'h0033, 2'h1},
      '{1'b1, 18'h00048, 32'h000000FF, 1'b1, 32'h00000000, 16'h0033, 2'h1},
      '{1'b1, 18'h00044, 32'h000000C3, 1'b0, 32'h00000000, 16'hC333, 2'h3},
      '{1'b0, 18'h10040, 32'h00000000, 1'b0, 32'h000000A5, 16'hC333, 2'h3},
      '{1'b0, 18'h0004C, 32'h00000000, 1'b1, 32'h00000000, 16'hC333, 2'h3},
      '{1'b1, 18'h00040, 32'h00000012, 1'b0, 32'h00000000, 16'hC312, 2'h3}};

   isolated_digital_io_port i_dut (.clk(clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .input_group_low_n(in_low_n), .input_group_high_n(in_high_n),
      .base_address_switch_a(sw_a), .base_address_switch_b(sw_b),
      .word_mode_jumper(word_j), .addr16_jumper(addr16_j), .protect_jumper(protect_j),
      .reset_link_jumper(link_j), .bus_reset_n(bus_reset_n),
      .output_group_low(out_low), .output_group_high(out_high),
      .output_led(output_led), .input_led(input_led), .reg_led_low(reg_led_low),
      .reg_led_high(reg_led_high), .data16_led(data16_led), .addr16_led(addr16_led),
      .reset_link_led(reset_link_led));

   host_model i_host (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (exp !== got)
      begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk_out(input logic [15:0] exp, input logic [1:0] leds);
      chk("outputs", exp, {out_high, out_low});
      chk("output_led", exp, output_led);
      chk("reg_leds", leds, {reg_led_high, reg_led_low});
   endtask

   task automatic bus_reset_pulse;
      bus_reset_n <= 1'b0;
      tick(2);
      bus_reset_n <= 1'b1;
      tick(6);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ************************************************************
   // Clock and watchdog
   // ************************************************************
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         report_and_stop();
      end
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      num_errors = 0;
      checks_done = 0;
      cycles = 0;
      resetn = 1'b0;
      in_low_n = 8'h5A;
      in_high_n = 8'h0F;
      sw_a = 8'h10;
      sw_b = 8'h00;
      word_j = 1'b0;
      addr16_j = 1'b0;
      protect_j = 1'b1;
      link_j = 1'b1;
      bus_reset_n = 1'b1;
      tick(16);
      resetn <= 1'b1;
      tick(5);
      chk_out(16'h0000, 2'h0);
      chk("cfg_leds", 3'h1, {data16_led, addr16_led, reset_link_led});
      chk("input_led", 16'hF0A5, input_led);
      $display("reset test done");
      foreach (rows[i])
      begin
         i_host.xfer(rows[i].wr, rows[i].addr, rows[i].data, rd, er);
         chk("pslverr", rows[i].err, er);
         chk("prdata", rows[i].rd, rd);
         tick(4);
         chk_out(rows[i].outx, rows[i].leds);
      end
      $display("table test done");
      bus_reset_pulse();
      chk_out(16'h0000, 2'h0);
      i_host.xfer(1'b1, 18'h00040, 32'h00000055, rd, er);
      tick(4);
      chk_out(16'h0055, 2'h1);
      link_j <= 1'b0;
      tick(5);
      chk("reset_link_led", 1'b0, reset_link_led);
      bus_reset_pulse();
      chk_out(16'h0055, 2'h1);
      $display("bus reset test done");
      word_j <= 1'b1;
      tick(5);
      chk("data16_led", 1'b1, data16_led);
      i_host.xfer(1'b1, 18'h00044, 32'h0000BEEF, rd, er);
      tick(4);
      chk_out(16'hBEEF, 2'h3);
      i_host.xfer(1'b0, 18'h00040, 32'h0, rd, er);
      chk("word read", 32'h0000F0A5, rd);
      $display("word mode test done");
      protect_j <= 1'b0;
      link_j <= 1'b1;
      tick(5);
      bus_reset_pulse();
      chk_out(16'hBEEF, 2'h0);
      protect_j <= 1'b1;
      tick(6);
      chk_out(16'h0000, 2'h0);
      $display("protection test done");
      in_low_n <= 8'hFF;
      in_high_n <= 8'h00;
      tick(5);
      chk("input_led", 16'hFF00, input_led);
      addr16_j <= 1'b1;
      sw_b <= 8'h12;
      tick(5);
      chk("addr16_led", 1'b1, addr16_led);
      i_host.xfer(1'b0, 18'h10040, 32'h0, rd, er);
      chk("alias err", 1'b1, er);
      i_host.xfer(1'b0, 18'h04840, 32'h0, rd, er);
      chk("base16 err", 1'b0, er);
      chk("base16 read", 32'h0000FF00, rd);
      i_host.xfer(1'b1, 18'h04840, 32'h00001234, rd, er);
      tick(4);
      chk_out(16'h1234, 2'h3);
      $display("address test done");
      resetn <= 1'b0;
      tick(2);
      resetn <= 1'b1;
      tick(5);
      chk_out(16'h0000, 2'h0);
      $display("mid-run reset test done");
      report_and_stop();
   end
endmodule
